//--- logic/mmdia_pkg.sv
// mmdia_pkg: constants for the indirect extended register access block.
// assumes one 16-bit clause 22 register port in front of the block.
package mmdia_pkg;

    // ********************************
    // register map and field layout
    // ********************************
    localparam int REG_ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam logic [4:0] REG_CTRL = 5'h0d;
    localparam logic [4:0] REG_WINDOW = 5'h0e;
    localparam int FUNC_MSB = 15;
    localparam int FUNC_LSB = 14;
    localparam int SPACE_MSB = 4;
    localparam int SPACE_LSB = 0;

    // ********************************
    // field encodings
    // ********************************
    localparam logic [1:0] FUNC_ADDR = 2'h0;
    localparam logic [1:0] FUNC_DATA = 2'h1;
    localparam logic [1:0] FUNC_INC_RW = 2'h2;
    localparam logic [1:0] FUNC_INC_WR = 2'h3;
    localparam logic [4:0] SPACE_VENDOR = 5'h1f;
    localparam logic [4:0] SPACE_PMA = 5'h01;

    // ********************************
    // reset values
    // ********************************
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [15:0] READ_IDLE = 16'h0000;

    // ********************************
    // extended space storage defaults
    // ********************************
    localparam int EXT_DEPTH_DEF = 32;
    localparam int EXT_DEPTH_MAX = 32768;
    localparam int NUM_SPACES = 2;
    localparam int IDX_VENDOR = 0;
    localparam int IDX_PMA = 1;

endpackage : mmdia_pkg

//--- logic/mmdia_ext_store.sv
// mmdia_ext_store: word storage behind one extended register space.
// assumes one write per cycle; the read port is combinational so the
// caller registers the answer.
`timescale 1ns/10ps

module mmdia_ext_store #(
    parameter int DEPTH = mmdia_pkg::EXT_DEPTH_DEF,
    parameter int IDX_W = $clog2(mmdia_pkg::EXT_DEPTH_DEF)
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic wr_en,
    input wire logic [IDX_W-1:0] wr_index,
    input wire logic [mmdia_pkg::DATA_W-1:0] wr_data,
    input wire logic [IDX_W-1:0] rd_index,
    output logic [mmdia_pkg::DATA_W-1:0] rd_data
);

    logic [mmdia_pkg::DATA_W-1:0] mem [DEPTH];

    // ********************************
    // elaboration checks
    // ********************************
    // the index must reach every word and nothing beyond
    if (DEPTH < 2 || (1 << IDX_W) != DEPTH) begin : g_bad_depth
        $error("DEPTH must be two to the power of IDX_W");
    end

    // ********************************
    // storage
    // ********************************
    // reset clears every word so reads before any write are defined
    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= mmdia_pkg::DATA_RESET;
            end
        end else if (wr_en) begin
            mem[wr_index] <= wr_data;
        end
    end

    assign rd_data = mem[rd_index];

endmodule : mmdia_ext_store

//--- logic/mmdia_top.sv
// mmdia_top: indirect access to two extended register spaces through
// an access control register and an address/data window register.
// assumes the serial management front end hands over one clause 22
// register read or write per cycle, synchronous to clk.
//
// Summary of operation
// - address function with pma target: window write loads the pma pointer
// - address function: window reads return the pointer, no side effects
// - data function: window write updates pointed register, pointer stays
// - data function: window read returns pointed register, pointer stays
// - rewriting control register never disturbs the stored pointers
// - data function with pma target reaches the pma space register
// - increment function: window write stores then advances pointer
// - inc both function: window read returns then advances pointer
// - write-only increment code accepted; window write advances pointer
// - both increment codes advance the pma pointer the same way on window writes
// - control bits 15:14 select address, data, inc both, inc writes
// - control bits 4:0 select the target extended space
// - window accesses with an unsupported target are ignored, read zero and raise window_ignored
// - write-only increment function: window reads keep the pointer
`timescale 1ns/10ps

module mmdia_top #(
    parameter int EXT_DEPTH = mmdia_pkg::EXT_DEPTH_DEF
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [mmdia_pkg::REG_ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [mmdia_pkg::DATA_W-1:0] reg_wdata,
    output logic [mmdia_pkg::DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    output logic window_ignored
);

    localparam int IDX_W = $clog2(EXT_DEPTH);

    // ********************************
    // elaboration checks
    // ********************************
    if (EXT_DEPTH < 2 || EXT_DEPTH > mmdia_pkg::EXT_DEPTH_MAX ||
        (EXT_DEPTH & (EXT_DEPTH - 1)) != 0) begin : g_bad_depth
        $error("EXT_DEPTH must be a power of two from 2 to 32768");
    end

    // ********************************
    // decode helpers
    // ********************************
    // shared by the write and read paths
    function automatic logic space_known(input logic [4:0] space);
        space_known = (space == mmdia_pkg::SPACE_VENDOR) ||
                      (space == mmdia_pkg::SPACE_PMA);
    endfunction : space_known

    function automatic logic space_slot(input logic [4:0] space);
        space_slot = (space == mmdia_pkg::SPACE_PMA);
    endfunction : space_slot

    // ********************************
    // state
    // ********************************
    logic [mmdia_pkg::DATA_W-1:0] access_ctrl;
    logic [mmdia_pkg::DATA_W-1:0] ext_addr [mmdia_pkg::NUM_SPACES];
    logic [mmdia_pkg::DATA_W-1:0] next_ext_addr [mmdia_pkg::NUM_SPACES];
    logic [mmdia_pkg::DATA_W-1:0] store_rdata [mmdia_pkg::NUM_SPACES];
    logic [mmdia_pkg::DATA_W-1:0] next_rdata;

    // ********************************
    // control field decode
    // ********************************
    wire [1:0] func;
    wire [4:0] target;
    wire target_ok;
    wire slot;
    wire [mmdia_pkg::DATA_W-1:0] cur_addr;
    wire in_range;
    wire [IDX_W-1:0] cur_index;

    assign func = access_ctrl[mmdia_pkg::FUNC_MSB:mmdia_pkg::FUNC_LSB];
    assign target = access_ctrl[mmdia_pkg::SPACE_MSB:mmdia_pkg::SPACE_LSB];
    assign target_ok = space_known(target);
    assign slot = space_slot(target);
    assign cur_addr = ext_addr[slot];
    // pointers beyond the built depth reach no storage
    assign in_range = (cur_addr[mmdia_pkg::DATA_W-1:IDX_W] == '0);
    assign cur_index = cur_addr[IDX_W-1:0];

    // ********************************
    // access decode
    // ********************************
    wire ctrl_wr;
    wire win_sel_wr;
    wire win_sel_rd;
    wire win_wr;
    wire win_rd;
    wire addr_fn;
    wire store_wr;
    wire inc_on_wr;
    wire inc_on_rd;
    wire bump;

    // a write in the same cycle as a read takes precedence
    assign ctrl_wr = reg_wr && (reg_addr == mmdia_pkg::REG_CTRL);
    assign win_sel_wr = reg_wr && (reg_addr == mmdia_pkg::REG_WINDOW);
    assign win_sel_rd = !reg_wr && reg_rd &&
                        (reg_addr == mmdia_pkg::REG_WINDOW);
    assign win_wr = win_sel_wr && target_ok;
    assign win_rd = win_sel_rd && target_ok;
    assign addr_fn = (func == mmdia_pkg::FUNC_ADDR);
    assign store_wr = win_wr && !addr_fn && in_range;
    assign inc_on_wr = win_wr && ((func == mmdia_pkg::FUNC_INC_RW) ||
                                  (func == mmdia_pkg::FUNC_INC_WR));
    assign inc_on_rd = win_rd && (func == mmdia_pkg::FUNC_INC_RW);
    assign bump = inc_on_wr || inc_on_rd;

    // ********************************
    // pointer update
    // ********************************
    for (genvar s = 0; s < mmdia_pkg::NUM_SPACES; s++) begin : g_ptr
        wire mine;
        assign mine = (slot == 1'(s));
        assign next_ext_addr[s] =
            (mine && win_wr && addr_fn) ? reg_wdata :
            (mine && bump) ? cur_addr + 16'h0001 :
            ext_addr[s];

        always_ff @(posedge clk) begin
            if (!nrst) begin
                ext_addr[s] <= mmdia_pkg::ADDR_RESET;
            end else begin
                ext_addr[s] <= next_ext_addr[s];
            end
        end

        mmdia_ext_store #(
            .DEPTH(EXT_DEPTH),
            .IDX_W(IDX_W)
        ) u_store (
            .clk(clk),
            .nrst(nrst),
            .wr_en(store_wr && mine),
            .wr_index(cur_index),
            .wr_data(reg_wdata),
            .rd_index(cur_index),
            .rd_data(store_rdata[s])
        );
    end

    // ********************************
    // control register
    // ********************************
    always_ff @(posedge clk) begin
        if (!nrst) begin
            access_ctrl <= mmdia_pkg::CTRL_RESET;
        end else if (ctrl_wr) begin
            access_ctrl <= reg_wdata;
        end
    end

    // ********************************
    // read path
    // ********************************
    wire ctrl_rd;
    wire [mmdia_pkg::DATA_W-1:0] win_data;

    assign ctrl_rd = !reg_wr && reg_rd && (reg_addr == mmdia_pkg::REG_CTRL);
    assign win_data = addr_fn ? cur_addr :
                      in_range ? store_rdata[slot] : mmdia_pkg::READ_IDLE;
    // other register numbers belong to neighbouring logic and read zero
    assign next_rdata = ctrl_rd ? access_ctrl :
                        win_rd ? win_data : mmdia_pkg::READ_IDLE;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            reg_rdata <= mmdia_pkg::READ_IDLE;
            reg_rvalid <= 1'b0;
            window_ignored <= 1'b0;
        end else begin
            reg_rdata <= next_rdata;
            reg_rvalid <= !reg_wr && reg_rd;
            window_ignored <= (win_sel_wr || win_sel_rd) && !target_ok;
        end
    end

endmodule : mmdia_top

//--- test/mmdia_asserts.sv
// mmdia_asserts: port checks for mmdia_top
// assumes a bind onto mmdia_top
`timescale 1ns/10ps
module mmdia_asserts #(
    parameter int EXT_DEPTH = 32
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [4:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic window_ignored
);
    // control copy built from inputs only
    logic [15:0] ctrl_q;
    wire logic rd_ok = reg_rd && !reg_wr;
    wire logic win = reg_addr == mmdia_pkg::REG_WINDOW;
    wire logic ctl = reg_addr == mmdia_pkg::REG_CTRL;
    wire logic bad = ctrl_q[4:0] != 5'h1f && ctrl_q[4:0] != 5'h01;
    wire logic [1:0] fn = ctrl_q[15:14];
    always_ff @(posedge clk) begin
        if (!nrst) ctrl_q <= 16'h0000;
        else if (reg_wr && ctl) ctrl_q <= reg_wdata;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_rv; rd_ok |=> reg_rvalid; endproperty
    a_rv: assert property (p_rv) else $error("read lost");
    property p_nr; !rd_ok |=> !reg_rvalid && reg_rdata == 0; endproperty
    a_nr: assert property (p_nr) else $error("stray answer");
    property p_ct;
        reg_wr && ctl ##1 rd_ok && ctl |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_ct: assert property (p_ct) else $error("control readback");
    property p_ig; (reg_wr || reg_rd) && win && bad |=> window_ignored;
    endproperty
    a_ig: assert property (p_ig) else $error("bad target used");
    property p_ok; (reg_wr || reg_rd) && win && !bad |=> !window_ignored;
    endproperty
    a_ok: assert property (p_ok) else $error("target dropped");
    property p_ad;
        reg_wr && win && !bad && fn == 0 ##1 rd_ok && win
            |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_ad: assert property (p_ad) else $error("pointer load");
    property p_ar;
        (rd_ok && win && !bad && fn == 0) [*2] |=> $stable(reg_rdata);
    endproperty
    a_ar: assert property (p_ar) else $error("pointer reread");
    property p_dr;
        (rd_ok && win && !bad && fn[0]) [*2] |=> $stable(reg_rdata);
    endproperty
    a_dr: assert property (p_dr) else $error("pointer moved");
    c_inc: cover property (reg_wr && win && fn == 2'h2);
    c_ign: cover property (window_ignored);
    c_b2b: cover property (reg_rvalid ##1 reg_rvalid);
endmodule : mmdia_asserts

//--- test/mmdia_station.sv
// mmdia_station: management station driving the register port
// assumes the bench orders the requests
`timescale 1ns/10ps
module mmdia_station (
    input wire logic clk,
    output logic [4:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [15:0] reg_wdata
);
    initial begin
        reg_addr = 5'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
    end
    // one request a cycle; data is garbage unless writing
    task automatic put(input logic w, input logic r, input logic [4:0] a,
                       input logic [15:0] d);
        @(negedge clk);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= w ? d : ~reg_wdata;
    endtask : put
endmodule : mmdia_station

//--- test/tb_mmd_indirect_register_access.sv
// tb_mmd_indirect_register_access: self-checking bench for mmdia_top
// assumes the station model and checker are compiled first
`timescale 1ns/10ps
module tb_mmd_indirect_register_access;
    localparam int DEPTH = 4;
    localparam logic [4:0] CT = mmdia_pkg::REG_CTRL;
    localparam logic [4:0] WN = mmdia_pkg::REG_WINDOW;
    logic clk;
    logic nrst;
    logic [4:0] reg_addr;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic reg_rvalid;
    logic window_ignored;
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc = 0;
    logic [15:0] ctrl = 16'h0000;
    logic [15:0] ptr [2] = '{default: 16'h0000};
    logic [15:0] mem [2][DEPTH] = '{default: 16'h0000};
    logic [16:0] rd_q [$];
    logic ign_q [$];
    mmdia_top #(.EXT_DEPTH(DEPTH)) u_mmdia_top (.clk, .nrst, .reg_addr,
        .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
        .window_ignored);
    mmdia_station u_mmdia_station (.clk, .reg_addr, .reg_wr, .reg_rd,
        .reg_wdata);
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_ig(input logic got, input logic exp);
        chk({16'h0000, got}, {16'h0000, exp});
    endtask : chk_ig
    task automatic results();
        if (n_mismatch == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results
    // expected answer worked out before the request goes out
    task automatic acc(input logic w, input logic [4:0] a,
                       input logic [15:0] d);
        int s;
        logic [15:0] e;
        s = ctrl[4:0] == 5'h1f ? 0 : ctrl[4:0] == 5'h01 ? 1 : 2;
        e = 16'h0000;
        if (a == CT) begin
            e = ctrl;
            if (w) ctrl = d;
        end else if (a == WN && s < 2) begin
            if (ctrl[15:14] == mmdia_pkg::FUNC_ADDR) begin
                e = ptr[s];
                if (w) ptr[s] = d;
            end else begin
                if (ptr[s] < DEPTH) e = mem[s][ptr[s]];
                if (w && ptr[s] < DEPTH) mem[s][ptr[s]] = d;
                if (ctrl[15] && (w || !ctrl[14])) ptr[s]++;
            end
        end
        u_mmdia_station.put(w, !w, a, d);
        // every request notes its answer: writes expect no rvalid
        rd_q.push_back(w ? 17'h00000 : {1'b1, e});
        ign_q.push_back(a == WN && s == 2);
    endtask : acc
    // results land at the rising edge that follows the request edge
    always @(posedge clk) begin
        #1;
        cyc++;
        if (ign_q.size() > 0)
            chk_ig(window_ignored, ign_q.pop_front());
        else chk_ig(window_ignored, 1'b0);
        if (rd_q.size() > 0)
            chk({reg_rvalid, reg_rdata}, rd_q.pop_front());
        else chk({reg_rvalid, reg_rdata}, 17'h00000);
        if (cyc > 3000) begin
            n_mismatch++;
            results();
        end
    end
    initial begin
        logic [15:0] t;
        void'($urandom(32'hda73d9e9));
        nrst = 1'b0;
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        acc(0, CT, 0);
        acc(0, WN, 0);
        acc(1, CT, 16'h001f);
        acc(1, WN, 16'h0002);
        acc(0, WN, 0);
        acc(0, WN, 0);
        acc(1, CT, 16'h401f);
        acc(1, WN, 16'($urandom));
        acc(1, WN, 16'($urandom));
        acc(0, WN, 0);
        acc(0, WN, 0);
        acc(1, CT, 16'h0001);
        acc(1, WN, 16'h0003);
        acc(0, WN, 0);
        acc(1, CT, 16'h4001);
        acc(1, WN, 16'($urandom));
        acc(0, WN, 0);
        acc(1, CT, 16'h001f);
        acc(0, WN, 0);
        for (int sp = 0; sp < 2; sp++) for (int f = 2; f < 4; f++) begin
            t = sp ? 16'h0001 : 16'h001f;
            acc(1, CT, t);
            acc(1, WN, 0);
            acc(1, CT, {f[1:0], t[13:0]});
            repeat (DEPTH + 1) acc(1, WN, 16'($urandom));
            acc(1, CT, t);
            acc(1, WN, 0);
            acc(1, CT, {f[1:0], t[13:0]});
            repeat (DEPTH + 1) acc(0, WN, 0);
            acc(1, CT, t);
            acc(0, WN, 0);
        end
        acc(1, CT, 16'h4002);
        acc(0, CT, 0);
        acc(1, WN, 16'h1234);
        acc(0, WN, 0);
        acc(0, 5'h05, 0);
        // write beats a read in the same cycle: no answer, write lands
        u_mmdia_station.put(1, 1, CT, 16'h401f);
        ctrl = 16'h401f;
        rd_q.push_back(17'h00000);
        ign_q.push_back(1'b0);
        acc(0, CT, 0);
        acc(1, CT, 16'h4001);
        acc(0, WN, 0);
        repeat (3) u_mmdia_station.put(0, 0, 5'h00, 16'h0000);
        chk(17'(rd_q.size()), 17'h00000);
        results();
    end
endmodule : tb_mmd_indirect_register_access
bind mmdia_top mmdia_asserts #(.EXT_DEPTH(EXT_DEPTH)) u_mmdia_asserts (
    .clk, .nrst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .reg_rvalid, .window_ignored);
